// >>> motion_engine_model.sv
// Behavioural model of the motion engine facing the sequencer.
// Assumes the sequencer's start, hold and abort outputs on the same clock.
`timescale 1ns/1ps
`default_nettype none

module motion_engine_model #(
  parameter int DUR = 20
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic hold_i,
  input  wire logic abort_i,
  output logic      busy_o,
  output logic      done_o,
  output logic      in_band_o
);
  int left_r;

  // Counts a move down; hold freezes the remainder and abort discards it.
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i || abort_i) begin
      left_r <= 0;
    end else if (start_i) begin
      left_r <= DUR;
    end else if (left_r > 0 && !hold_i) begin
      left_r <= left_r - 1;
      done_o <= (left_r == 1);
    end
  end

  // The axis sits in band whenever no travel is left.
  assign busy_o    = (left_r > 0);
  assign in_band_o = (left_r == 0);
endmodule

`default_nettype wire

// >>> positioner_io_handshake.sv
// Discrete-I/O command and status sequencer of an actuator positioner.
// Assumes PLC inputs synchronous to clk_i and an external motion engine that
// runs the servo loop and reports busy, done, in-band and homing reversal.
// Operation
// - Start edge captures position number, begins move.
// - Start before homing raises home-incomplete error.
// - Binary weights two to n-1, max 1500.
// - Setting selects binary or BCD decoding.
// - Pause stops, keeps remaining distance, resumes.
// - Cancel stops and discards remaining distance.
// - Homing pause holds, after reversal restarts homing.
// - Home edge homes; repeatable after first completion.
// - Servo off ignores start and home silently.
// - Servo drop mid-move finishes move first.
// - Error clear edge; cold errors need power cycle.
// - Push uses entry n+1, current acc times 100.
// - Interpolation launches both axes, arrives together.
// - Positioning complete at ready when in band.
// - Complete drops on start, returns after start off.
// - Complete stays set when deviation leaves band.
// - Complete off while paused or servo off.
// - Home complete off at power-up, sticky.
// - Alarm low on cancellation-level or higher error.
// - Ready after initialization, off on cold error.
// - Servo status shows energized; PLC waits for it.
// - Inputs change only after 6 ms stable.
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module positioner_io_handshake
  import positioner_pkg::*;
#(
  parameter int unsigned FILTER_CYCLES = FILTER_CYC,
  parameter int unsigned ACC_W         = 8
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              start_move_in_i,
  input  wire logic [POS_W-1:0]  position_bit_in_i,
  input  wire logic              pause_n_in_i,
  input  wire logic              cancel_travel_in_i,
  input  wire logic              home_in_i,
  input  wire logic              servo_enable_in_i,
  input  wire logic              error_clear_in_i,
  input  wire logic              push_mode_in_i,
  input  wire logic              interp_mode_in_i,
  output logic                   in_position_done_out_o,
  output logic                   homing_done_out_o,
  output logic                   healthy_n_alarm_out_o,
  output logic                   ready_out_o,
  output logic                   servo_energized_out_o,
  input  wire logic              init_ok_i,
  input  wire logic              fault_cancel_i,
  input  wire logic              fault_cold_i,
  input  wire logic              move_busy_i,
  input  wire logic              move_done_i,
  input  wire logic              in_band_i,
  input  wire logic              home_reversed_i,
  input  wire logic [ACC_W-1:0]  push_acc_i,
  output move_cmd_s              move_cmd_o,
  output logic                   move_start_o,
  output logic [1:0]             axis_start_o,
  output logic                   move_hold_o,
  output logic                   move_abort_o,
  output logic [ACC_W+6:0]       current_limit_o
);

  localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] FLT_LAST = CW'(FILTER_CYCLES - 1);

  // Decodes the position inputs; returns validity in the top bit.
  function automatic logic [NUM_W:0] decode_pos(input logic [POS_W-1:0] b, input logic bcd);
    logic [NUM_W-1:0] v;
    logic             ok;
    v  = '0;
    ok = 1'b1;
    if (bcd) begin
      ok = (b[3:0] < 4'ha) && (b[7:4] < 4'ha) && (b[11:8] < 4'ha);
      v  = NUM_W'(b[3:0]) + NUM_W'(b[7:4]) * NUM_W'(7'h0a) +
           NUM_W'(b[11:8]) * NUM_W'(7'h64) + (b[12] ? 11'h3e8 : 11'h000);
    end else begin
      ok = (b[12:NUM_W] == 2'h0);
      v  = b[NUM_W-1:0];
    end
    ok = ok && (v <= POS_MAX);
    return {ok, v};
  endfunction

  logic [NIN-1:0]  raw;
  logic [NIN-1:0]  filt_r;
  logic [CW-1:0]   flt_cnt_r [NIN];
  logic            start_q_r;
  logic            home_q_r;
  logic            clear_q_r;
  logic            start_ev;
  logic            home_ev;
  logic            clear_ev;
  logic            start_f;
  logic            pause_f;
  logic            cancel_f;
  logic            servo_f;
  logic [NUM_W:0]  pos_dec;
  seq_state_e      state_r;
  logic            restart_r;
  logic            homing_done_out_r;
  logic            in_position_done_out_r;
  logic            ready_r;
  logic            servo_energized_out_r;
  logic            err_cancel_travel_in_r;
  logic            err_cold_r;
  logic [11:0]     err_code_r;
  logic            bcd_r;
  logic            ack_r;
  logic [31:0]     rdata_nxt;
  logic            accept_start;
  logic            accept_home;
  logic            err_home_inc;
  logic            err_bad_pos;

  assign raw = {position_bit_in_i, error_clear_in_i, interp_mode_in_i, cancel_travel_in_i,
                pause_n_in_i, push_mode_in_i, servo_enable_in_i, home_in_i, start_move_in_i};

  // Each input takes a new level only after it has differed for the full window.
  always_ff @(posedge clk_i) begin
    for (int unsigned g = 0; g < NIN; g++) begin
      if (rst_i) begin
        flt_cnt_r[g] <= '0;
        filt_r[g]    <= (g == IDX_PAUSE_N);
      end else if (raw[g] == filt_r[g]) begin
        flt_cnt_r[g] <= '0;
      end else if (flt_cnt_r[g] == FLT_LAST) begin
        flt_cnt_r[g] <= '0;
        filt_r[g]    <= raw[g];
      end else begin
        flt_cnt_r[g] <= flt_cnt_r[g] + 1'b1;
      end
    end
  end

  assign start_f  = filt_r[IDX_START];
  assign pause_f  = filt_r[IDX_PAUSE_N];
  assign cancel_f = filt_r[IDX_CANCEL];
  assign servo_f  = filt_r[IDX_SERVO];
  assign pos_dec  = decode_pos(filt_r[IDX_POS +: POS_W], bcd_r);

  // Edge detectors act on filtered levels, one event per rising change.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q_r <= 1'b0;
      home_q_r  <= 1'b0;
      clear_q_r <= 1'b0;
    end else begin
      start_q_r <= start_f;
      home_q_r  <= filt_r[IDX_HOME];
      clear_q_r <= filt_r[IDX_CLEAR];
    end
  end
  assign start_ev = start_f && !start_q_r;
  assign home_ev  = filt_r[IDX_HOME] && !home_q_r;
  assign clear_ev = filt_r[IDX_CLEAR] && !clear_q_r;

  // Command acceptance; servo off drops commands without any error.
  assign accept_start = start_ev && servo_energized_out_r && (state_r == ST_IDLE) && !err_cancel_travel_in_r
                        && !err_cold_r && homing_done_out_r && pos_dec[NUM_W];
  assign err_home_inc = start_ev && servo_energized_out_r && (state_r == ST_IDLE) && !homing_done_out_r;
  assign err_bad_pos  = start_ev && servo_energized_out_r && (state_r == ST_IDLE) && homing_done_out_r && !pos_dec[NUM_W];
  assign accept_home  = home_ev && servo_energized_out_r && (state_r == ST_IDLE) && !err_cancel_travel_in_r
                        && !err_cold_r && !start_ev;

  // Sequencer for moves, homing, pause and cancel.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r      <= ST_IDLE;
      restart_r    <= 1'b0;
      move_start_o <= 1'b0;
      axis_start_o <= 2'h0;
      move_cmd_o   <= '0;
    end else begin
      move_start_o <= 1'b0;
      axis_start_o <= 2'h0;
      case (state_r)
        ST_IDLE: begin
          if (accept_start) begin
            move_cmd_o.target      <= pos_dec[NUM_W-1:0];
            move_cmd_o.param_entry <= pos_dec[NUM_W-1:0] + 1'b1;
            move_cmd_o.push        <= filt_r[IDX_PUSH];
            move_cmd_o.interp      <= filt_r[IDX_INTERP];
            move_cmd_o.home        <= 1'b0;
            move_start_o           <= 1'b1;
            axis_start_o           <= filt_r[IDX_INTERP] ? 2'h3 : 2'h1;
            state_r                <= ST_MOVING;
          end else if (accept_home) begin
            move_cmd_o.home <= 1'b1;
            move_cmd_o.push <= 1'b0;
            move_start_o    <= 1'b1;
            axis_start_o    <= 2'h3;
            state_r         <= ST_HOMING;
          end
        end
        ST_MOVING: begin
          if (cancel_f || err_cancel_travel_in_r || err_cold_r) begin
            state_r <= ST_STOPPING;
          end else if (!pause_f) begin
            state_r <= ST_PAUSED;
          end else if (move_done_i) begin
            state_r <= ST_IDLE;
          end
        end
        ST_PAUSED: begin
          if (cancel_f || err_cancel_travel_in_r || err_cold_r) begin
            state_r <= ST_STOPPING;
          end else if (pause_f) begin
            state_r <= ST_MOVING;
          end
        end
        ST_HOMING: begin
          if (cancel_f || err_cancel_travel_in_r || err_cold_r) begin
            state_r <= ST_STOPPING;
          end else if (!pause_f) begin
            restart_r <= home_reversed_i;
            state_r   <= ST_HOME_HOLD;
          end else if (move_done_i) begin
            state_r <= ST_IDLE;
          end
        end
        ST_HOME_HOLD: begin
          if (cancel_f || err_cancel_travel_in_r || err_cold_r) begin
            state_r <= ST_STOPPING;
          end else if (pause_f) begin
            move_start_o <= restart_r;
            axis_start_o <= restart_r ? 2'h3 : 2'h0;
            restart_r    <= 1'b0;
            state_r      <= ST_HOMING;
          end
        end
        ST_STOPPING: begin
          if (!move_busy_i) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Hold keeps the remaining travel; abort discards it or drops homing before restart.
  assign move_hold_o  = (state_r == ST_PAUSED) || ((state_r == ST_HOME_HOLD) && !restart_r);
  assign move_abort_o = (state_r == ST_STOPPING) || ((state_r == ST_HOME_HOLD) && restart_r);

  // Push current limit is the next entry's acceleration scaled by one hundred.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      current_limit_o <= '0;
    end else if (accept_start) begin
      current_limit_o <= (ACC_W+7)'(push_acc_i) * (ACC_W+7)'(PUSH_CUR_MUL);
    end
  end

  // Home complete clears on a new home command and sets when homing finishes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      homing_done_out_r <= 1'b0;
    end else if (state_r == ST_HOMING && pause_f && !cancel_f && move_done_i) begin
      homing_done_out_r <= 1'b1;
    end else if (accept_home) begin
      homing_done_out_r <= 1'b0;
    end
  end

  // Positioning complete: set only when idle, start off, in band, ready, servo on and unpaused.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_position_done_out_r <= 1'b0;
    end else if (start_ev || !pause_f || !servo_energized_out_r || state_r != ST_IDLE) begin
      in_position_done_out_r <= 1'b0;
    end else if (!start_f && in_band_i && ready_r) begin
      in_position_done_out_r <= 1'b1;
    end
  end

  // Ready latches after initialization; servo status follows the enable but drops mid-move only on a cold error.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_r <= 1'b0;
      servo_energized_out_r  <= 1'b0;
    end else begin
      if (init_ok_i) begin
        ready_r <= 1'b1;
      end
      if (err_cold_r || !ready_r) begin
        servo_energized_out_r <= 1'b0;
      end else if (servo_f) begin
        servo_energized_out_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        servo_energized_out_r <= 1'b0;
      end
    end
  end

  // Error flags; a new error in the clear cycle wins, cold errors ignore clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_cancel_travel_in_r <= 1'b0;
      err_cold_r <= 1'b0;
      err_code_r <= ERR_NONE;
    end else begin
      if (fault_cold_i) begin
        err_cold_r <= 1'b1;
        err_code_r <= ERR_EXT_COLD;
      end else if (err_home_inc) begin
        err_cancel_travel_in_r <= 1'b1;
        err_code_r <= ERR_HOME_INC;
      end else if (err_bad_pos) begin
        err_cancel_travel_in_r <= 1'b1;
        err_code_r <= ERR_BAD_POS;
      end else if (fault_cancel_i) begin
        err_cancel_travel_in_r <= 1'b1;
        err_code_r <= ERR_EXT_CANCEL_TRAVEL_IN;
      end else if (clear_ev && !err_cold_r) begin
        err_cancel_travel_in_r <= 1'b0;
        err_code_r <= ERR_NONE;
      end
    end
  end

  assign in_position_done_out_o = in_position_done_out_r;
  assign homing_done_out_o      = homing_done_out_r;
  assign healthy_n_alarm_out_o  = !(err_cancel_travel_in_r || err_cold_r);
  assign ready_out_o            = ready_r && !err_cold_r;
  assign servo_energized_out_o  = servo_energized_out_r;

  // Wishbone slave: one wait state, ack drops the cycle after it was given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r    <= wb_cyc_i && wb_stb_i && !ack_r;
      wb_dat_o <= rdata_nxt;
    end
  end
  assign wb_ack_o = ack_r;

  // Control register write; takes effect on the acknowledging edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcd_r <= CTRL_BCD_RST;
    end else if (wb_cyc_i && wb_stb_i && ack_r && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        bcd_r <= wb_dat_i[CTRL_BCD_BIT];
      end
    end
  end

  // Read decode; unmapped addresses read zero.
  always_comb begin
    rdata_nxt = '0;
    if (wb_adr_i == REG_CTRL) begin
      rdata_nxt[CTRL_BCD_BIT] = bcd_r;
    end else if (wb_adr_i == REG_STATUS) begin
      rdata_nxt[10:0] = {state_r, 1'b0, err_cold_r, err_cancel_travel_in_r, servo_energized_out_r, ready_out_o,
                         healthy_n_alarm_out_o, homing_done_out_r, in_position_done_out_r};
    end else if (wb_adr_i == REG_TARGET) begin
      rdata_nxt[NUM_W-1:0] = move_cmd_o.target;
    end else if (wb_adr_i == REG_ERRCODE) begin
      rdata_nxt[11:0] = err_code_r;
    end
  end

  // Checks on the sequencer and outputs.
  AST_START_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    accept_start |=> (move_start_o && move_cmd_o.target == $past(pos_dec[NUM_W-1:0])))
    else $error("start edge did not capture target");
  AST_HOME_INC: assert property (@(posedge clk_i) disable iff (rst_i)
    (err_home_inc && !fault_cold_i) |=> (!healthy_n_alarm_out_o && !move_start_o
    && err_code_r == ERR_HOME_INC))
    else $error("home-incomplete error not raised");
  AST_SERVO_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
    ((start_ev || home_ev) && !servo_energized_out_r) |=> (!move_start_o && $stable(err_code_r)
    || $past(fault_cold_i) || $past(fault_cancel_i)))
    else $error("command accepted with servo off");
  AST_PAUSE_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_r == ST_MOVING && !pause_f && !cancel_f && !err_cancel_travel_in_r && !err_cold_r)
    |=> move_hold_o ##1 (move_hold_o || !$past(move_hold_o) || state_r != ST_PAUSED))
    else $error("pause did not hold travel");
  AST_CANCEL: assert property (@(posedge clk_i) disable iff (rst_i)
    ((state_r == ST_MOVING || state_r == ST_PAUSED) && cancel_f) |=> move_abort_o)
    else $error("cancel did not abort travel");
  AST_SERVO_KEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    (servo_energized_out_r && state_r == ST_MOVING && !err_cold_r) |=> servo_energized_out_o)
    else $error("servo dropped during a move");
  AST_IN_POSITION_DONE_OUT_START: assert property (@(posedge clk_i) disable iff (rst_i)
    start_f |=> !in_position_done_out_o)
    else $error("positioning complete while start held");
  AST_IN_POSITION_DONE_OUT_PAUSE: assert property (@(posedge clk_i) disable iff (rst_i)
    (!pause_f || !servo_energized_out_r) |=> !in_position_done_out_o)
    else $error("positioning complete while paused or servo off");
  AST_HOMING_DONE_OUT_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    (homing_done_out_r && !home_ev) |=> homing_done_out_r)
    else $error("home complete dropped without home command");
  AST_COLD_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    err_cold_r |=> (err_cold_r && !ready_out_o && !healthy_n_alarm_out_o))
    else $error("cold error cleared without reset");
  AST_FILTER: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_f != $past(start_f)) |-> ($past(flt_cnt_r[IDX_START]) == FLT_LAST))
    else $error("start level changed before stable window");

endmodule

`default_nettype wire

// >>> positioner_pkg.sv
// Shared constants, types and register map of the positioner discrete-I/O block.
// Assumes a single 200 MHz clock and a classic Wishbone register bus of 32 bits.
package positioner_pkg;

  // Clock rate and input stability window.
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned FILTER_MS     = 6;
  localparam int unsigned FILTER_CYC    = (FILTER_MS * (CLK_HZ / 1000));

  // Position numbering.
  localparam int unsigned POS_W         = 13;
  localparam int unsigned NUM_W         = 11;
  localparam logic [NUM_W-1:0] POS_MAX  = 11'h5dc;
  localparam logic [7:0]  PUSH_CUR_MUL  = 8'h64;

  // Bit positions inside the filtered input vector.
  localparam int unsigned IDX_START     = 0;
  localparam int unsigned IDX_HOME      = 1;
  localparam int unsigned IDX_SERVO     = 2;
  localparam int unsigned IDX_PUSH      = 3;
  localparam int unsigned IDX_PAUSE_N   = 4;
  localparam int unsigned IDX_CANCEL    = 5;
  localparam int unsigned IDX_INTERP    = 6;
  localparam int unsigned IDX_CLEAR     = 7;
  localparam int unsigned IDX_POS       = 8;
  localparam int unsigned NIN           = IDX_POS + POS_W;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_TARGET     = 8'h08;
  localparam logic [7:0] REG_ERRCODE    = 8'h0c;

  // Control register fields and reset value.
  localparam int unsigned CTRL_BCD_BIT  = 0;
  localparam logic        CTRL_BCD_RST  = 1'b0;

  // Error codes reported in the error-code register.
  localparam logic [11:0] ERR_NONE      = 12'h000;
  localparam logic [11:0] ERR_HOME_INC  = 12'hc6f;
  localparam logic [11:0] ERR_BAD_POS   = 12'h0a1;
  localparam logic [11:0] ERR_EXT_CANCEL_TRAVEL_IN  = 12'h0e1;
  localparam logic [11:0] ERR_EXT_COLD  = 12'h0e2;

  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_MOVING,
    ST_PAUSED,
    ST_HOMING,
    ST_HOME_HOLD,
    ST_STOPPING
  } seq_state_e;

  // Command handed to the motion engine.
  typedef struct packed {
    logic [NUM_W-1:0] target;
    logic [NUM_W-1:0] param_entry;
    logic             push;
    logic             interp;
    logic             home;
  } move_cmd_s;

endpackage

// >>> test_positioner_io_handshake.sv
// Self-checking bench of the positioner discrete-I/O sequencer.
// Assumes a short input filter and the motion engine model at the far side.
`timescale 1ns/1ps
`default_nettype none

module test_positioner_io_handshake;
  import positioner_pkg::*;
  localparam int F = 4;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic wb_ack_o, start_move_in_i = 0, pause_n_in_i = 1, cancel_travel_in_i = 0;
  logic [POS_W-1:0] position_bit_in_i = 0;
  logic home_in_i = 0, servo_enable_in_i = 0, error_clear_in_i = 0, push_mode_in_i = 0;
  logic interp_mode_in_i = 0, init_ok_i = 0, fault_cancel_i = 0, fault_cold_i = 0;
  logic in_position_done_out_o, homing_done_out_o, healthy_n_alarm_out_o, ready_out_o;
  logic servo_energized_out_o, move_busy_i, move_done_i, in_band_i, move_start_o;
  logic move_hold_o, move_abort_o, home_reversed_i = 0;
  logic [7:0] push_acc_i = 0;
  logic [1:0] axis_start_o, axis_seen;
  logic [14:0] current_limit_o;
  move_cmd_s move_cmd_o;
  int bad_count = 0, checks_done = 0;

  positioner_io_handshake #(.FILTER_CYCLES(F)) positioner_io_handshake_inst (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .start_move_in_i, .position_bit_in_i, .pause_n_in_i,
    .cancel_travel_in_i, .home_in_i, .servo_enable_in_i, .error_clear_in_i,
    .push_mode_in_i, .interp_mode_in_i, .in_position_done_out_o, .homing_done_out_o,
    .healthy_n_alarm_out_o, .ready_out_o, .servo_energized_out_o, .init_ok_i,
    .fault_cancel_i, .fault_cold_i, .move_busy_i, .move_done_i, .in_band_i,
    .home_reversed_i, .push_acc_i, .move_cmd_o, .move_start_o, .axis_start_o,
    .move_hold_o, .move_abort_o, .current_limit_o);

  motion_engine_model motion_engine_model_inst (.clk_i, .rst_i, .start_i(move_start_o),
    .hold_i(move_hold_o), .abort_i(move_abort_o), .busy_o(move_busy_i),
    .done_o(move_done_i), .in_band_o(in_band_i));

  // Clock of 5 ns period.
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Keeps the axis pattern of the latest launch.
  always @(posedge clk_i) begin
    if (move_start_o === 1'b1) axis_seen <= axis_start_o;
  end

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // One classic Wishbone cycle; read data is taken at the ack edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Lets a changed input pass the stability filter.
  task automatic flt();
    repeat (F + 3) @(posedge clk_i);
  endtask

  task automatic wait_hi(input int k);
    int n;
    n = 0;
    while ((k == 0 ? in_position_done_out_o : homing_done_out_o) !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 300) begin
      bad_count++;
      end_of_test();
    end
  endtask

  // Full move to one entry with start held past arrival.
  task automatic move(input logic [12:0] p, input logic [31:0] exp);
    position_bit_in_i <= p;
    flt();
    start_move_in_i <= 1'b1;
    flt();
    chk("in_position_done_out_at_start", in_position_done_out_o, 0);
    repeat (40) @(posedge clk_i);
    chk("in_position_done_out_start_on", in_position_done_out_o, 0);
    bus(0, REG_TARGET, 0);
    chk("target", q, exp);
    start_move_in_i <= 1'b0;
    wait_hi(0);
  endtask

  task automatic t_reset();
    chk("ready_pre_init", ready_out_o, 0);
    init_ok_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("ready", ready_out_o, 1);
    chk("alarm_n", healthy_n_alarm_out_o, 1);
    chk("homing_done_out", homing_done_out_o, 0);
    chk("in_position_done_out", in_position_done_out_o, 0);
    bus(0, REG_CTRL, 0);
    chk("ctrl", q, 0);
    bus(0, 8'h40, 0);
    chk("unmapped", q, 0);
    $display("Test reset done");
  endtask

  task automatic t_servo_off();
    home_in_i <= 1'b1;
    flt();
    home_in_i <= 1'b0;
    flt();
    chk("homing_done_out", homing_done_out_o, 0);
    bus(0, REG_ERRCODE, 0);
    chk("errcode", q, ERR_NONE);
    $display("Test servo off done");
  endtask

  task automatic t_no_home();
    servo_enable_in_i <= 1'b1;
    flt();
    chk("servo_energized_out", servo_energized_out_o, 1);
    start_move_in_i <= 1'b1;
    flt();
    start_move_in_i <= 1'b0;
    bus(0, REG_ERRCODE, 0);
    chk("errcode", q, ERR_HOME_INC);
    chk("alarm_n", healthy_n_alarm_out_o, 0);
    error_clear_in_i <= 1'b1;
    flt();
    error_clear_in_i <= 1'b0;
    chk("alarm_n", healthy_n_alarm_out_o, 1);
    $display("Test home incomplete done");
  endtask

  task automatic t_home();
    home_in_i <= 1'b1;
    wait_hi(1);
    home_in_i <= 1'b0;
    flt();
    home_in_i <= 1'b1;
    flt();
    chk("homing_done_out_new_cmd", homing_done_out_o, 0);
    home_reversed_i <= 1'b1;
    pause_n_in_i <= 1'b0;
    flt();
    chk("home_abort", move_abort_o, 1);
    pause_n_in_i <= 1'b1;
    home_reversed_i <= 1'b0;
    wait_hi(1);
    home_in_i <= 1'b0;
    wait_hi(0);
    $display("Test home done");
  endtask

  task automatic t_moves();
    move(13'h05dc, 32'd1500);
    position_bit_in_i <= 13'h05dd;
    flt();
    start_move_in_i <= 1'b1;
    flt();
    start_move_in_i <= 1'b0;
    bus(0, REG_ERRCODE, 0);
    chk("bad_pos", q, ERR_BAD_POS);
    error_clear_in_i <= 1'b1;
    flt();
    error_clear_in_i <= 1'b0;
    flt();
    chk("bad_pos_clr", healthy_n_alarm_out_o, 1);
    bus(1, REG_CTRL, 1);
    move(13'h1234, 32'd1234);
    bus(1, REG_CTRL, 0);
    $display("Test moves done");
  endtask

  task automatic t_push_interp();
    push_mode_in_i <= 1'b1;
    interp_mode_in_i <= 1'b1;
    push_acc_i <= 8'h32;
    move(13'h0014, 32'd20);
    chk("axes", axis_seen, 2'h3);
    chk("current", current_limit_o, 15'h1388);
    chk("entry", move_cmd_o.param_entry, 11'h015);
    push_mode_in_i <= 1'b0;
    interp_mode_in_i <= 1'b0;
    $display("Test push done");
  endtask

  task automatic t_pause_cancel();
    position_bit_in_i <= 13'h0007;
    flt();
    start_move_in_i <= 1'b1;
    flt();
    pause_n_in_i <= 1'b0;
    flt();
    repeat (30) @(posedge clk_i);
    chk("hold", move_hold_o, 1);
    chk("in_position_done_out_paused", in_position_done_out_o, 0);
    pause_n_in_i <= 1'b1;
    start_move_in_i <= 1'b0;
    wait_hi(0);
    position_bit_in_i <= 13'h0009;
    flt();
    start_move_in_i <= 1'b1;
    flt();
    cancel_travel_in_i <= 1'b1;
    flt();
    bus(0, REG_STATUS, 0);
    chk("state", q[10:8], 3'h0);
    cancel_travel_in_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    bus(0, REG_STATUS, 0);
    chk("state", q[10:8], 3'h0);
    start_move_in_i <= 1'b0;
    $display("Test pause cancel done");
  endtask

  task automatic t_cold();
    fault_cancel_i <= 1'b1;
    @(posedge clk_i);
    fault_cancel_i <= 1'b0;
    bus(0, REG_ERRCODE, 0);
    chk("ext_cancel", q, ERR_EXT_CANCEL_TRAVEL_IN);
    chk("alarm_ext", healthy_n_alarm_out_o, 0);
    chk("ready_ext", ready_out_o, 1);
    fault_cold_i <= 1'b1;
    @(posedge clk_i);
    fault_cold_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk("ready", ready_out_o, 0);
    error_clear_in_i <= 1'b1;
    flt();
    chk("ready", ready_out_o, 0);
    chk("alarm_n", healthy_n_alarm_out_o, 0);
    $display("Test cold done");
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_reset();
    t_servo_off();
    t_no_home();
    t_home();
    t_moves();
    t_push_interp();
    t_pause_cancel();
    t_cold();
    end_of_test();
  end

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test();
  end
endmodule

`default_nettype wire
